// ---- common/sxe_pkg.sv ----
package sxe_pkg;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] OPC_SPECIAL2 = 6'h1C;
  localparam logic [5:0] OPC_SPECIAL3 = 6'h1F;
  localparam logic [5:0] OPC_COP1 = 6'h11;
  localparam logic [5:0] OPC_COP1X = 6'h13;
  localparam logic [5:0] OPC_COP2 = 6'h12;
  localparam logic [5:0] OPC_FP_DW_STORE = 6'h3D;
  localparam logic [5:0] OPC_CP2_DW_STORE = 6'h3E;
  localparam logic [5:0] FN_BRK_OLD = 6'h3F;
  localparam logic [5:0] FN_BRK_R6 = 6'h0E;
  localparam logic [5:0] FN_BSHFL = 6'h20;
  localparam logic [5:0] FN_FP_SELECT = 6'h10;
  localparam logic [5:0] FN_FP_IDX_STORE = 6'h09;
  localparam logic [4:0] SA_BYTE_EXT = 5'h10;
  localparam logic [4:0] SA_HALF_EXT = 5'h18;
  localparam logic [4:0] FMT_SINGLE = 5'h10;
  localparam logic [4:0] FMT_DOUBLE = 5'h11;
  localparam logic [4:0] RS_CP2_DW_R6 = 5'h0F;

  // ----------------------------------------------------------------
  // Values, offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] DBG_CODE_BP = 5'h09;
  localparam logic [2:0] HI_WORD_XOR = 3'h4;
  localparam logic [31:0] HI_WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [63:0] RST_DWORD = 64'h0000_0000_0000_0000;
  localparam logic [4:0] RST_DBG_CODE = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE, OP_BRK, OP_FP_DW, OP_CP2_DW, OP_FP_IDX_DW,
    OP_BYTE_EXT, OP_HALF_EXT, OP_FP_SEL
  } sxe_op_t;

  typedef enum logic [3:0] {
    EXC_NONE, EXC_RI, EXC_CPU, EXC_ADES, EXC_TLB_REFILL,
    EXC_TLB_INVALID, EXC_TLB_MOD, EXC_WATCH, EXC_DBG_BP,
    EXC_DBG_MODE_BP
  } sxe_exc_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HI = 3'b010,
    ST_END = 3'b100
  } sxe_state_t;

endpackage

// ---- common/sxe_ex_if.sv ----
`timescale 1ns/10ps
interface sxe_ex_if;
  import sxe_pkg::*;
  logic [31:0] instr;
  logic rel6;
  logic rev2;
  sxe_op_t op;
  logic ri;
  logic fmt_dbl;
  logic [31:0] gpr_a;
  logic [31:0] gpr_b;
  logic [63:0] fs_val;
  logic [63:0] ft_val;
  logic [63:0] fd_val;
  logic [31:0] ea;
  logic [31:0] ext_res;
  logic [63:0] sel_res;
  modport top (output instr, rel6, rev2, gpr_a, gpr_b, fs_val, ft_val,
    fd_val, input op, ri, fmt_dbl, ea, ext_res, sel_res);
  modport dec (input instr, rel6, rev2, output op, ri, fmt_dbl);
  modport alu (input instr, rel6, op, fmt_dbl, gpr_a, gpr_b, fs_val,
    ft_val, fd_val, output ea, ext_res, sel_res);
endinterface

// ---- hw/sxe_decode.sv ----
`timescale 1ns/10ps
module sxe_decode
  import sxe_pkg::*;
(
  sxe_ex_if.dec ex
);

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------
  wire [5:0] opc = ex.instr[31:26];
  wire [4:0] rs = ex.instr[25:21];
  wire [4:0] sa = ex.instr[10:6];
  wire [5:0] fn = ex.instr[5:0];

  // ----------------------------------------------------------------
  // Class match
  // ----------------------------------------------------------------
  wire brk_r6 = (opc == OPC_SPECIAL) && (fn == FN_BRK_R6);
  wire brk_old = (opc == OPC_SPECIAL2) && (fn == FN_BRK_OLD);
  wire is_brk = ex.rel6 ? brk_r6 : brk_old;
  wire is_fp_dw = opc == OPC_FP_DW_STORE;
  wire cp2_r6 = (opc == OPC_COP2) && (rs == RS_CP2_DW_R6);
  wire is_cp2_dw = ex.rel6 ? cp2_r6 : (opc == OPC_CP2_DW_STORE);
  wire is_idx = (opc == OPC_COP1X) && (fn == FN_FP_IDX_STORE);
  wire is_bshfl = (opc == OPC_SPECIAL3) && (rs == 5'h00) &&
    (fn == FN_BSHFL);
  wire is_bext = is_bshfl && (sa == SA_BYTE_EXT);
  wire is_hext = is_bshfl && (sa == SA_HALF_EXT);
  wire is_sel = ex.rel6 && (opc == OPC_COP1) && (fn == FN_FP_SELECT);
  wire fmt_ok = (rs == FMT_SINGLE) || (rs == FMT_DOUBLE);

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ex.op = is_brk ? OP_BRK :
    is_fp_dw ? OP_FP_DW :
    is_cp2_dw ? OP_CP2_DW :
    is_idx ? OP_FP_IDX_DW :
    is_bext ? OP_BYTE_EXT :
    is_hext ? OP_HALF_EXT :
    is_sel ? OP_FP_SEL : OP_NONE;
  assign ex.ri = (is_idx && (ex.rel6 || !ex.rev2)) ||
    ((is_bext || is_hext) && !ex.rev2) ||
    (is_sel && !fmt_ok);
  assign ex.fmt_dbl = rs == FMT_DOUBLE;

endmodule

// ---- hw/sxe_alu.sv ----
`timescale 1ns/10ps
module sxe_alu
  import sxe_pkg::*;
(
  sxe_ex_if.alu ex
);

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------
  wire [15:0] imm16 = ex.instr[15:0];
  wire [10:0] imm11 = ex.instr[10:0];
  wire [31:0] off16 = {{16{imm16[15]}}, imm16};
  wire [31:0] off11 = {{21{imm11[10]}}, imm11};
  wire cp2_short = ex.rel6 && (ex.op == OP_CP2_DW);
  wire [31:0] offset = (ex.op == OP_FP_IDX_DW) ? ex.gpr_b :
    cp2_short ? off11 : off16;
  assign ex.ea = ex.gpr_a + offset;

  // ----------------------------------------------------------------
  // Sign extend and select
  // ----------------------------------------------------------------
  wire [31:0] bext = {{24{ex.gpr_b[7]}}, ex.gpr_b[7:0]};
  wire [31:0] hext = {{16{ex.gpr_b[15]}}, ex.gpr_b[15:0]};
  assign ex.ext_res = (ex.op == OP_BYTE_EXT) ? bext : hext;
  wire [63:0] pick = ex.fd_val[0] ? ex.ft_val : ex.fs_val;
  assign ex.sel_res = ex.fmt_dbl ? pick : {32'h0000_0000, pick[31:0]};

endmodule

// ---- hw/sxe_top.sv ----
`timescale 1ns/10ps
module sxe_top
  import sxe_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Issue
  input wire logic in_valid,
  input wire logic [31:0] instr,
  // Operands
  input wire logic [31:0] gpr_a,
  input wire logic [31:0] gpr_b,
  input wire logic [63:0] fpr_fs,
  input wire logic [63:0] fpr_ft,
  input wire logic [63:0] fpr_fd,
  input wire logic [31:0] cop2_lo,
  input wire logic [31:0] cop2_hi,
  // Configuration
  input wire logic rel6_mode,
  input wire logic rev2_mode,
  input wire logic cp1_usable,
  input wire logic cp2_usable,
  input wire logic misalign_ok,
  input wire logic breakpoint_disable_cfg,
  input wire logic debug_mode_flag,
  input wire logic big_endian,
  input wire logic reverse_endian,
  // Translation answer
  input wire logic tlb_refill,
  input wire logic tlb_invalid,
  input wire logic tlb_modified,
  input wire logic watch_hit,
  // Results
  output logic ex_ready,
  output logic gpr_we,
  output logic fpr_we,
  output logic [63:0] wb_data,
  output logic st_valid,
  output logic [31:0] st_vaddr,
  output logic [31:0] st_addr,
  output logic [31:0] st_data,
  output logic exc_valid,
  output logic [3:0] exc_code,
  output logic [4:0] debug_exception_code_field
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Decode and datapath
  // ----------------------------------------------------------------
  sxe_ex_if ex ();

  assign ex.instr = instr;
  assign ex.rel6 = rel6_mode;
  assign ex.rev2 = rev2_mode;
  assign ex.gpr_a = gpr_a;
  assign ex.gpr_b = gpr_b;
  assign ex.fs_val = fpr_fs;
  assign ex.ft_val = fpr_ft;
  assign ex.fd_val = fpr_fd;

  sxe_decode u_dec (.ex(ex));
  sxe_alu u_alu (.ex(ex));

  // ----------------------------------------------------------------
  // Issue checks
  // ----------------------------------------------------------------
  sxe_state_t state_reg;
  sxe_state_t state_next;
  logic ex_ready_reg;

  wire take = in_valid && ex_ready_reg;
  wire op_fp_dw = ex.op == OP_FP_DW;
  wire op_cp2 = ex.op == OP_CP2_DW;
  wire op_idx = ex.op == OP_FP_IDX_DW;
  wire op_ext = (ex.op == OP_BYTE_EXT) || (ex.op == OP_HALF_EXT);
  wire op_sel = ex.op == OP_FP_SEL;
  wire is_store = op_fp_dw || op_cp2 || op_idx;
  wire cop_off = ((op_fp_dw || op_idx || op_sel) && !cp1_usable) ||
    (op_cp2 && !cp2_usable);
  wire misal = ex.ea[2:0] != 3'h0;
  wire ade = is_store && misal &&
    (op_idx || !(rel6_mode && misalign_ok));
  wire [3:0] brk_exc = breakpoint_disable_cfg ? EXC_RI :
    debug_mode_flag ? EXC_DBG_MODE_BP : EXC_DBG_BP;
  wire [3:0] issue_exc = cop_off ? EXC_CPU :
    ex.ri ? EXC_RI :
    (ex.op == OP_BRK) ? brk_exc :
    ade ? EXC_ADES : EXC_NONE;
  wire issue_ok = take && (issue_exc == EXC_NONE);

  // ----------------------------------------------------------------
  // Store words
  // ----------------------------------------------------------------
  wire [63:0] fp_word = op_idx ? fpr_fs : fpr_ft;
  wire [31:0] lo_data = op_cp2 ? cop2_lo : fp_word[31:0];
  wire [31:0] hi_data = op_cp2 ? cop2_hi : fp_word[63:32];
  wire flip = big_endian ^ reverse_endian;
  wire [31:0] lo_addr = {ex.ea[31:3], ex.ea[2] ^ flip, ex.ea[1:0]};
  wire [31:0] hi_addr = {lo_addr[31:3], lo_addr[2:0] ^ HI_WORD_XOR};
  wire [31:0] hi_vaddr = ex.ea + HI_WORD_STEP;

  // ----------------------------------------------------------------
  // Translation faults
  // ----------------------------------------------------------------
  wire fault = tlb_refill || tlb_invalid || tlb_modified || watch_hit;
  wire [3:0] fault_exc = tlb_refill ? EXC_TLB_REFILL :
    tlb_invalid ? EXC_TLB_INVALID :
    tlb_modified ? EXC_TLB_MOD : EXC_WATCH;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = (issue_ok && is_store) ? ST_HI : ST_IDLE;
      ST_HI: state_next = fault ? ST_IDLE : ST_END;
      ST_END: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  wire in_idle = state_reg == ST_IDLE;
  wire in_hi = state_reg == ST_HI;
  wire in_end = state_reg == ST_END;
  wire lo_go = in_idle && issue_ok && is_store;
  wire hi_go = in_hi && !fault;
  wire fault_exc_go = (in_hi || in_end) && fault;
  wire issue_exc_go = in_idle && take && (issue_exc != EXC_NONE);
  wire dm_bp = issue_exc_go && (issue_exc == EXC_DBG_MODE_BP);

  // ----------------------------------------------------------------
  // Held upper word
  // ----------------------------------------------------------------
  logic [31:0] hold_data_reg;
  logic [31:0] hold_addr_reg;
  logic [31:0] hold_vaddr_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_data_reg <= RST_WORD;
      hold_addr_reg <= RST_WORD;
      hold_vaddr_reg <= RST_WORD;
    end else if (lo_go) begin
      hold_data_reg <= hi_data;
      hold_addr_reg <= hi_addr;
      hold_vaddr_reg <= hi_vaddr;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic gpr_we_reg;
  logic fpr_we_reg;
  logic [63:0] wb_data_reg;
  logic st_valid_reg;
  logic [31:0] st_vaddr_reg;
  logic [31:0] st_addr_reg;
  logic [31:0] st_data_reg;
  logic exc_valid_reg;
  logic [3:0] exc_code_reg;
  logic [4:0] dbg_code_reg;

  wire [63:0] wb_data_next = op_sel ? ex.sel_res :
    {32'h0000_0000, ex.ext_res};
  wire [31:0] st_vaddr_next = lo_go ? ex.ea : hold_vaddr_reg;
  wire [31:0] st_addr_next = lo_go ? lo_addr : hold_addr_reg;
  wire [31:0] st_data_next = lo_go ? lo_data : hold_data_reg;
  wire [3:0] exc_code_next = fault_exc_go ? fault_exc : issue_exc;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      ex_ready_reg <= 1'b0;
      gpr_we_reg <= 1'b0;
      fpr_we_reg <= 1'b0;
      wb_data_reg <= RST_DWORD;
      st_valid_reg <= 1'b0;
      st_vaddr_reg <= RST_WORD;
      st_addr_reg <= RST_WORD;
      st_data_reg <= RST_WORD;
      exc_valid_reg <= 1'b0;
      exc_code_reg <= EXC_NONE;
      dbg_code_reg <= RST_DBG_CODE;
    end else begin
      state_reg <= state_next;
      ex_ready_reg <= state_next == ST_IDLE;
      gpr_we_reg <= in_idle && issue_ok && op_ext;
      fpr_we_reg <= in_idle && issue_ok && op_sel;
      wb_data_reg <= wb_data_next;
      st_valid_reg <= lo_go || hi_go;
      st_vaddr_reg <= st_vaddr_next;
      st_addr_reg <= st_addr_next;
      st_data_reg <= st_data_next;
      exc_valid_reg <= issue_exc_go || fault_exc_go;
      exc_code_reg <= exc_code_next;
      dbg_code_reg <= dm_bp ? DBG_CODE_BP : RST_DBG_CODE;
    end
  end

  assign ex_ready = ex_ready_reg;
  assign gpr_we = gpr_we_reg;
  assign fpr_we = fpr_we_reg;
  assign wb_data = wb_data_reg;
  assign st_valid = st_valid_reg;
  assign st_vaddr = st_vaddr_reg;
  assign st_addr = st_addr_reg;
  assign st_data = st_data_reg;
  assign exc_valid = exc_valid_reg;
  assign exc_code = exc_code_reg;
  assign debug_exception_code_field = dbg_code_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_brk_off;
    take && ex.op == OP_BRK && breakpoint_disable_cfg |=>
      exc_valid && exc_code == EXC_RI && debug_exception_code_field == 5'h00;
  endproperty
  a_brk_off: assert property (p_brk_off) else $error("bp not RI");

  property p_brk_dm;
    take && ex.op == OP_BRK && !breakpoint_disable_cfg && debug_mode_flag
      |=> exc_code == EXC_DBG_MODE_BP && debug_exception_code_field == 5'h09;
  endproperty
  a_brk_dm: assert property (p_brk_dm) else $error("bad nested bp");

  property p_brk_norm;
    take && ex.op == OP_BRK && !breakpoint_disable_cfg && !debug_mode_flag
      |=> exc_valid && exc_code == EXC_DBG_BP;
  endproperty
  a_brk_norm: assert property (p_brk_norm) else $error("bad bp");

  property p_fp_lo;
    take && op_fp_dw && issue_exc == EXC_NONE |=>
      st_valid && st_data == $past(fpr_ft[31:0]) ##1 (fault ||
      $past(fault) || (st_valid && st_data == $past(fpr_ft[63:32], 2)));
  endproperty
  a_fp_lo: assert property (p_fp_lo) else $error("fp store data");

  property p_align;
    take && is_store && !rel6_mode && !cop_off && !ex.ri && misal |=>
      exc_valid && exc_code == EXC_ADES && !st_valid;
  endproperty
  a_align: assert property (p_align) else $error("no addr error");

  property p_hi_word;
    st_valid && in_hi && !fault |=> st_valid &&
      st_vaddr == $past(st_vaddr) + 32'h0000_0004 &&
      st_addr[2:0] == ($past(st_addr[2:0]) ^ 3'h4);
  endproperty
  a_hi_word: assert property (p_hi_word) else $error("bad hi word");

  property p_r6_off;
    take && rel6_mode && op_cp2 |->
      ex.ea == gpr_a + {{21{instr[10]}}, instr[10:0]};
  endproperty
  a_r6_off: assert property (p_r6_off) else $error("cp2 offset");

  property p_idx;
    take && op_idx && !rel6_mode && rev2_mode && cp1_usable |->
      (ex.ea == gpr_a + gpr_b) && (misal == (issue_exc == EXC_ADES));
  endproperty
  a_idx: assert property (p_idx) else $error("indexed store");

  property p_idx_r6;
    take && op_idx && rel6_mode && cp1_usable |=>
      exc_code == EXC_RI && !st_valid;
  endproperty
  a_idx_r6: assert property (p_idx_r6) else $error("indexed in r6");

  property p_fault;
    st_valid && tlb_refill |=> exc_valid && exc_code == EXC_TLB_REFILL &&
      !st_valid;
  endproperty
  a_fault: assert property (p_fault) else $error("lost tlb fault");

  property p_bext;
    take && ex.op == OP_BYTE_EXT && rev2_mode |=> gpr_we &&
      wb_data[31:0] == {{24{$past(gpr_b[7])}}, $past(gpr_b[7:0])};
  endproperty
  a_bext: assert property (p_bext) else $error("byte extend");

  property p_hext;
    take && ex.op == OP_HALF_EXT && rev2_mode |=> gpr_we &&
      wb_data[31:0] == {{16{$past(gpr_b[15])}}, $past(gpr_b[15:0])};
  endproperty
  a_hext: assert property (p_hext) else $error("half extend");

  property p_ext_old;
    take && op_ext && !rev2_mode |=> exc_code == EXC_RI && !gpr_we;
  endproperty
  a_ext_old: assert property (p_ext_old) else $error("extend pre r2");

  property p_sel;
    take && op_sel && !ex.ri && cp1_usable |=> fpr_we && !exc_valid &&
      wb_data[31:0] == ($past(fpr_fd[0]) ? $past(fpr_ft[31:0]) :
      $past(fpr_fs[31:0]));
  endproperty
  a_sel: assert property (p_sel) else $error("fp select");

  property p_sel_fmt;
    take && op_sel && cp1_usable && instr[25:21] != 5'h10 &&
      instr[25:21] != 5'h11 |=> exc_code == EXC_RI && !fpr_we;
  endproperty
  a_sel_fmt: assert property (p_sel_fmt) else $error("select fmt");

endmodule

// ---- verif/sxe_mem_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------
// Translation answer model
// ------------------------------------------
module sxe_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Store word
  input wire logic st_valid,
  // Fault kind and word chosen by scenario
  input wire logic [2:0] fault_kind,
  input wire logic fault_hi,
  // Answer in the cycle of the word
  output logic tlb_refill,
  output logic tlb_invalid,
  output logic tlb_modified,
  output logic watch_hit
);
  logic phase_reg;
  logic hit;
  assign hit = st_valid && phase_reg == fault_hi && fault_kind != 3'h0;
  assign tlb_refill = hit && fault_kind == 3'h1;
  assign tlb_invalid = hit && fault_kind == 3'h2;
  assign tlb_modified = hit && fault_kind == 3'h3;
  assign watch_hit = hit && fault_kind == 3'h4;
  // Low word then high word, fault ends pair
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 1'b0;
    end else if (st_valid) begin
      phase_reg <= !phase_reg && !hit;
    end
  end
endmodule

// ---- verif/sxe_top_tb_top.sv ----
`timescale 1ns/10ps
// ------------------------------------------
// Bench
// ------------------------------------------
module sxe_top_tb_top;
  import sxe_pkg::*;
  logic clk, nrst, in_valid, rel6_mode, rev2_mode, cp1_usable, cp2_usable;
  logic misalign_ok, breakpoint_disable_cfg, debug_mode_flag, big_endian;
  logic reverse_endian, tlb_refill, tlb_invalid, tlb_modified, watch_hit;
  logic ex_ready, gpr_we, fpr_we, st_valid, exc_valid, fault_hi;
  logic [31:0] instr, gpr_a, gpr_b, cop2_lo, cop2_hi, st_vaddr, st_addr;
  logic [31:0] st_data;
  logic [63:0] fpr_fs, fpr_ft, fpr_fd, wb_data, last_wb, ex;
  logic [3:0] exc_code, last_exc;
  logic [4:0] debug_exception_code_field, last_dbg;
  logic [2:0] fault_kind;
  logic [31:0] sa[4], sv[4], sd[4];
  int n_errors, comparisons, cyc, n_exc, n_wb, n_st, n_busy;

  sxe_top sxe_top_inst (.clk, .nrst, .in_valid, .instr, .gpr_a, .gpr_b,
    .fpr_fs, .fpr_ft, .fpr_fd, .cop2_lo, .cop2_hi, .rel6_mode, .rev2_mode,
    .cp1_usable, .cp2_usable, .misalign_ok, .breakpoint_disable_cfg,
    .debug_mode_flag, .big_endian, .reverse_endian, .tlb_refill,
    .tlb_invalid, .tlb_modified, .watch_hit, .ex_ready, .gpr_we, .fpr_we,
    .wb_data, .st_valid, .st_vaddr, .st_addr, .st_data, .exc_valid,
    .exc_code, .debug_exception_code_field);
  sxe_mem_model sxe_mem_model_inst (.clk, .nrst, .st_valid, .fault_kind,
    .fault_hi, .tlb_refill, .tlb_invalid, .tlb_modified, .watch_hit);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(negedge clk) begin
    if (ex_ready === 1'b0) n_busy++;
    if (exc_valid === 1'b1) begin
      n_exc++;
      last_exc = exc_code;
      last_dbg = debug_exception_code_field;
    end
    if (gpr_we === 1'b1 || fpr_we === 1'b1) begin
      n_wb++;
      last_wb = wb_data;
    end
    if (st_valid === 1'b1 && n_st < 4) begin
      sa[n_st] = st_addr;
      sv[n_st] = st_vaddr;
      sd[n_st] = st_data;
      n_st++;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task exc_is(input sxe_exc_t e);
    chk(64'(n_exc), (e == EXC_NONE) ? 64'h0 : 64'h1);
    chk(64'(last_exc), 64'(e));
  endtask

  // Issue one word, then let the whole operation drain
  task run(input logic [31:0] i);
    @(negedge clk);
    while (ex_ready !== 1'b1) @(negedge clk);
    n_exc = 0;
    n_wb = 0;
    n_st = 0;
    n_busy = 0;
    last_exc = 4'h0;
    last_dbg = 5'h00;
    @(posedge clk);
    instr <= i;
    in_valid <= 1'b1;
    @(posedge clk);
    in_valid <= 1'b0;
    repeat (6) @(negedge clk);
  endtask

  function logic [31:0] fsd(input logic [15:0] imm);
    return {OPC_FP_DW_STORE, 5'h01, 5'h02, imm};
  endfunction

  task st_chk(input logic [31:0] va, input logic [63:0] d);
    logic [31:0] pa;
    pa = va ^ {29'h0, big_endian ^ reverse_endian, 2'h0};
    chk(64'(n_st), 64'h2);
    chk(64'(n_busy), 64'h2);
    chk({sv[0], sa[0]}, {va, pa});
    chk({sv[1], sa[1]}, {va + 32'h4, pa ^ 32'h4});
    chk({sd[1], sd[0]}, d);
    exc_is(EXC_NONE);
  endtask

  task t_ext;
    logic [31:0] v[4];
    v = '{32'h0000_0080, 32'hFFFF_FF7F, 32'h1234_8000, 32'h0000_7FFF};
    for (int j = 0; j < 5; j++) begin
      @(posedge clk);
      gpr_b <= v[j % 4];
      rev2_mode <= (j < 4);
      run({OPC_SPECIAL3, 10'h002, 5'h03, SA_BYTE_EXT, FN_BSHFL});
      ex = {32'h0, {24{v[j % 4][7]}}, v[j % 4][7:0]};
      if (j < 4) chk(last_wb, ex);
      exc_is(j < 4 ? EXC_NONE : EXC_RI);
      run({OPC_SPECIAL3, 10'h002, 5'h03, SA_HALF_EXT, FN_BSHFL});
      ex = {32'h0, {16{v[j % 4][15]}}, v[j % 4][15:0]};
      if (j < 4) chk(last_wb, ex);
      exc_is(j < 4 ? EXC_NONE : EXC_RI);
    end
    chk(64'(n_wb), 64'h0);
  endtask

  task t_bp;
    sxe_exc_t e[4];
    e = '{EXC_DBG_BP, EXC_DBG_MODE_BP, EXC_RI, EXC_RI};
    for (int j = 0; j < 5; j++) begin
      @(posedge clk);
      rel6_mode <= (j < 4);
      rev2_mode <= 1'b1;
      breakpoint_disable_cfg <= j[1];
      debug_mode_flag <= j[0] || j == 4;
      if (j < 4) run({OPC_SPECIAL, 20'hABCDE, FN_BRK_R6});
      else run({OPC_SPECIAL2, 20'h12345, FN_BRK_OLD});
      exc_is(j < 4 ? e[j] : EXC_DBG_MODE_BP);
      chk(64'(last_dbg), (j == 1 || j == 4) ? 64'h9 : 64'h0);
    end
  endtask

  task t_sel;
    for (int j = 0; j < 5; j++) begin
      @(posedge clk);
      rel6_mode <= 1'b1;
      fpr_fd <= {63'h7FFF_FFFF_FFFF_FFFF, j[0]};
      run({OPC_COP1, j == 4 ? 5'h14 : j[1] ? FMT_DOUBLE : FMT_SINGLE,
        15'h0443, FN_FP_SELECT});
      ex = j[0] ? fpr_ft : fpr_fs;
      if (!j[1]) ex[63:32] = 32'h0;
      if (j < 4) chk(last_wb, ex);
      exc_is(j < 4 ? EXC_NONE : EXC_RI);
    end
  endtask

  task t_st;
    @(posedge clk);
    rel6_mode <= 1'b0;
    gpr_a <= 32'h0000_1010;
    gpr_b <= 32'h0000_0FF8;
    big_endian <= 1'b1;
    run(fsd(16'hFFF8));
    st_chk(32'h0000_1008, fpr_ft);
    @(posedge clk);
    big_endian <= 1'b0;
    reverse_endian <= 1'b1;
    run({OPC_CP2_DW_STORE, 10'h022, 16'h0020});
    st_chk(32'h0000_1030, {cop2_hi, cop2_lo});
    run({OPC_COP1X, 15'h0443, 5'h00, FN_FP_IDX_STORE});
    st_chk(32'h0000_2008, fpr_fs);
    @(posedge clk);
    gpr_a <= 32'h0000_1014;
    run(fsd(16'h0000));
    exc_is(EXC_ADES);
    run({OPC_CP2_DW_STORE, 10'h022, 16'h0000});
    exc_is(EXC_ADES);
    run({OPC_COP1X, 15'h0443, 5'h00, FN_FP_IDX_STORE});
    exc_is(EXC_ADES);
    chk(64'(n_st), 64'h0);
    @(posedge clk);
    rel6_mode <= 1'b1;
    gpr_a <= 32'h0000_1010;
    run({OPC_COP1X, 15'h0443, 5'h00, FN_FP_IDX_STORE});
    exc_is(EXC_RI);
    run({OPC_COP2, RS_CP2_DW_R6, 10'h041, 11'h7F8});
    st_chk(32'h0000_1008, {cop2_hi, cop2_lo});
    @(posedge clk);
    misalign_ok <= 1'b1;
    gpr_a <= 32'h0000_1014;
    run(fsd(16'h0000));
    st_chk(32'h0000_1014, fpr_ft);
    @(posedge clk);
    gpr_a <= 32'h0000_1010;
  endtask

  task t_flt;
    for (int k = 0; k < 7; k++) begin
      @(posedge clk);
      rel6_mode <= 1'b0;
      fault_kind <= (k < 5) ? 3'(k + (k == 0)) : 3'h0;
      fault_hi <= (k != 0);
      cp1_usable <= (k != 5);
      cp2_usable <= (k != 6);
      if (k < 6) run(fsd(16'h0008));
      else run({OPC_CP2_DW_STORE, 10'h022, 16'h0008});
      if (k < 5) exc_is(sxe_exc_t'(k + 3 + (k == 0)));
      else exc_is(EXC_CPU);
      chk(64'(n_st), (k == 0) ? 64'h1 : (k < 5) ? 64'h2 : 64'h0);
    end
  endtask

  initial begin
    nrst = 1'b0;
    in_valid = 1'b0;
    instr = 32'h0;
    gpr_a = 32'h0;
    gpr_b = 32'h0;
    fpr_fs = 64'h7FF8_0000_DEAD_BEEF;
    fpr_ft = 64'hFFF0_0000_0000_0001;
    fpr_fd = 64'h0;
    cop2_lo = 32'h89AB_CDEF;
    cop2_hi = 32'h0123_4567;
    {rel6_mode, misalign_ok, big_endian, reverse_endian} = 4'h0;
    {rev2_mode, cp1_usable, cp2_usable} = 3'h7;
    {breakpoint_disable_cfg, debug_mode_flag, fault_hi} = 3'h0;
    fault_kind = 3'h0;
    {n_errors, comparisons, cyc, n_exc, n_wb, n_st, n_busy} = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_ext();
    t_bp();
    t_sel();
    t_st();
    t_flt();
    print_verdict();
  end
endmodule
